// >>> cbtaf_pkg.sv
// package of constants, register map and types for the can bit timing and acceptance filter block
// ==========================================================================
// Notes on behaviour
// - nominal bit spans 4 to 25 quanta
// - sample between spans, launch at span-two end
// - sync segment is exactly one quantum
// - idle falling edge hard-synchronises as frame start
// - phase error signed by edge position
// - small error resyncs like hard sync
// - large error stretches span one, shrinks two
// - jump width limit; resync on falling edges
// - prescaler divides clock into quanta
// - bit rate equals clock over prescale times length
// - fields decode with +2, +1, +1 offsets
// - fifteen buffers of eight 16-bit words
// - frame stored in first matching buffer only
// - status write raises tx_request; remote answers schedule all
// - shared mask for 0-13, catch-all for 14
// - scan ascending from buffer zero
// - mask bit one means don't care
// - hold option locks buffer until rearmed
// - all matches locked means frame dropped
// - copy only at validation point
// - copy overwrites id and length, unchecked
// - status codes 0000b, 0010b, 0100b
// - copy takes at least 17 clocks
package cbtaf_pkg;
  // ==========================================================================
  // register byte offsets
  localparam logic [11:0] TIMING_CONFIG_OFFS = 12'h000; // timing_config_register
  localparam logic [11:0] SHARED_MASK_OFFS = 12'h004;   // shared_id_mask
  localparam logic [11:0] CATCHALL_MASK_OFFS = 12'h008; // catchall_id_mask
  localparam logic [11:0] CONFIG_OFFS = 12'h00c;        // enable and hold_after_receive
  localparam logic [11:0] STATUS_OFFS = 12'h010;        // timing and filter state
  localparam logic [11:0] HIDDEN_ID_OFFS = 12'h014;     // test load of hidden frame id
  localparam logic [11:0] HIDDEN_CTL_OFFS = 12'h018;    // hidden frame length, remote flag, valid trigger
  localparam logic [11:0] BUF_BASE_OFFS = 12'h400;      // buffer ram window
  // ==========================================================================
  // timing register field positions
  localparam int PRESC_LSB = 0;   // 6-bit prescale field
  localparam int SPAN1_LSB = 8;   // 4-bit first span field
  localparam int SPAN2_LSB = 12;  // 3-bit second span field
  localparam int SJW_LSB = 16;    // 2-bit jump width field
  localparam logic [31:0] TIMING_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  // decoded offsets
  localparam logic [6:0] PRESC_ADD = 7'h02;
  localparam logic [4:0] SPAN_ADD = 5'h01;
  localparam logic [4:0] BIT_TQ_MIN = 5'h04;
  localparam logic [4:0] BIT_TQ_MAX = 5'h19;
  localparam logic [4:0] IDLE_BITS = 5'h0b; // recessive bits before idle
  // ==========================================================================
  // buffers
  localparam int NUM_BUF = 15;
  localparam int WORDS_PER_BUF = 8;
  localparam int CATCHALL_BUF = 14;
  localparam int W_CTL = 0;   // word 0: control word, status in [3:0], length in [15:12]
  localparam int W_IDH = 1;   // word 1: id high half
  localparam int W_IDL = 2;   // word 2: id low half
  localparam logic [3:0] ST_RX_NOT_ACTIVE = 4'h0;
  localparam logic [3:0] ST_RX_READY = 4'h2;
  localparam logic [3:0] ST_RX_FULL = 4'h4;
  localparam logic [3:0] ST_RX_OVERRUN = 4'h6;
  localparam logic [3:0] ST_TX_NOT_ACTIVE = 4'h8;
  localparam logic [3:0] ST_TX_RTR = 4'ha;
  localparam logic [3:0] ST_TX_ONCE = 4'hc;
  localparam logic [3:0] ST_TX_ONCE_RTR = 4'he;
  localparam logic [4:0] COPY_CYCLES = 5'h11; // 17 clocks
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  // ==========================================================================
  typedef enum logic [1:0] {CBTAF_SYNC, CBTAF_SEG1, CBTAF_SEG2} cbtaf_seg_e;
  typedef enum logic [1:0] {CBTAF_IDLE, CBTAF_SCAN, CBTAF_COPY} cbtaf_flt_e;
endpackage : cbtaf_pkg

// >>> cbtaf_top.sv
// can bit timing unit and receive acceptance filter with axi4-lite register access
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module cbtaf_top (
  input wire logic aclk,              // module_input_clock, 10 MHz
  input wire logic aresetn,           // synchronous reset, active low
  input wire logic can_rx,            // serial bus receive pin
  output logic can_tx,                // serial bus transmit pin
  output logic sample_strobe,         // one-cycle pulse at sample point
  output logic tx_point,              // one-cycle pulse at transmit point
  output logic tx_request,            // some buffer is scheduled to transmit
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid,     // write address valid
  output logic s_axi_awready,         // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid,      // write data valid
  output logic s_axi_wready,          // write data ready
  output logic [1:0] s_axi_bresp,     // write response
  output logic s_axi_bvalid,          // write response valid
  input wire logic s_axi_bready,      // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid,     // read address valid
  output logic s_axi_arready,         // read address ready
  output logic [31:0] s_axi_rdata,    // read data
  output logic [1:0] s_axi_rresp,     // read response
  output logic s_axi_rvalid,          // read valid
  input wire logic s_axi_rready       // read ready
);
  import cbtaf_pkg::*;
  // ==========================================================================
  // registers
  logic [31:0] timing_config_register; // prescale, spans, jump width
  logic [31:0] shared_id_mask;         // mask for buffers 0..13
  logic [31:0] catchall_id_mask;       // mask for buffer 14
  logic can_enable;                    // bit timing enable
  logic hold_after_receive;            // lock buffers after one frame
  logic [31:0] hidden_id;              // hidden receive buffer identifier
  logic [3:0] hidden_len;              // hidden receive buffer length code
  logic hidden_remote;                 // hidden frame is a remote frame
  logic [15:0] buf_mem [NUM_BUF*WORDS_PER_BUF]; // message buffer ram
  logic [NUM_BUF-1:0] locked;          // per buffer lock state
  logic frame_valid;                   // validation point reached, pulse
  // ==========================================================================
  // pin synchroniser: first stage read only by the second
  logic rx_meta;
  logic rx_sync;
  logic rx_prev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= can_rx;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end
  logic fall_edge;
  assign fall_edge = rx_prev & ~rx_sync;
  // ==========================================================================
  // field decode
  logic [6:0] presc_val;
  logic [4:0] span1_len;
  logic [4:0] span2_len;
  logic [4:0] sjw_len;
  assign presc_val = {1'b0, timing_config_register[PRESC_LSB +: 6]} + PRESC_ADD;
  assign span1_len = {1'b0, timing_config_register[SPAN1_LSB +: 4]} + SPAN_ADD;
  assign span2_len = {2'b00, timing_config_register[SPAN2_LSB +: 3]} + SPAN_ADD;
  assign sjw_len = {3'b000, timing_config_register[SJW_LSB +: 2]} + SPAN_ADD;
  // bit length in quanta, 4..25 when legal
  logic [4:0] bit_tq;
  logic timing_legal;
  assign bit_tq = 5'(span1_len + span2_len + 5'h01);
  assign timing_legal = (bit_tq >= BIT_TQ_MIN) && (bit_tq <= BIT_TQ_MAX);
  // ==========================================================================
  // quantum prescaler: tq_tick is a one-cycle enable
  logic [6:0] presc_cnt;
  logic tq_tick;
  logic resync_load; // reload request from sync logic
  assign tq_tick = (presc_cnt == 7'(presc_val - 7'h01));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_cnt <= 7'h00;
    end else if (!can_enable || resync_load) begin
      presc_cnt <= 7'h00;
    end else if (tq_tick) begin
      presc_cnt <= 7'h00;
    end else begin
      presc_cnt <= 7'(presc_cnt + 7'h01);
    end
  end
  // ==========================================================================
  // bit segment counter
  cbtaf_seg_e seg;
  logic [4:0] seg_cnt;       // quanta elapsed in this segment
  logic [4:0] seg1_target;   // span one length incl. lengthening
  logic [4:0] seg2_target;   // span two length after shortening
  logic bus_idle;
  logic [4:0] idle_cnt;
  logic sampled_bit;
  logic signed [11:0] err_clk;  // phase error in module clocks
  logic signed [11:0] sjw_clk;  // jump width in module clocks
  // error: zero in sync, positive in span one, negative in span two
  always_comb begin
    case (seg)
      CBTAF_SYNC: err_clk = 12'sh000;
      CBTAF_SEG1: err_clk = $signed({5'h00, seg_cnt} * {5'h00, presc_val}) + $signed({5'h00, presc_cnt});
      CBTAF_SEG2: err_clk = -$signed(({5'h00, seg2_target} - {5'h00, seg_cnt}) * {5'h00, presc_val})
                            + $signed({5'h00, presc_cnt});
      default: err_clk = 12'sh000;
    endcase
  end
  assign sjw_clk = $signed({7'h00, sjw_len} * {5'h00, presc_val});
  // resync event classification
  logic hard_sync;
  logic small_err;
  // idle falling edge is frame start
  assign hard_sync = can_enable && fall_edge && bus_idle;
  // small error acts as hard sync
  assign small_err = (err_clk <= sjw_clk) && (err_clk >= -sjw_clk);
  assign resync_load = hard_sync || (can_enable && fall_edge && !bus_idle && seg != CBTAF_SYNC && small_err);
  // sample at span one end, launch at span two end
  assign sample_strobe = tq_tick && (seg == CBTAF_SEG1) && (seg_cnt == 5'(seg1_target - 5'h01));
  assign tx_point = tq_tick && (seg == CBTAF_SEG2) && (seg_cnt >= 5'(seg2_target - 5'h01));
  // bit lasts bit_tq quanta of presc_val clocks
  // segment sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn || !can_enable || !timing_legal) begin
      seg <= CBTAF_SYNC;
      seg_cnt <= 5'h00;
      seg1_target <= 5'h01;
      seg2_target <= 5'h01;
    end else if (resync_load) begin
      // restart the bit as after sync segment
      seg <= CBTAF_SEG1;
      seg_cnt <= 5'h00;
      seg1_target <= span1_len;
      seg2_target <= span2_len;
    end else if (fall_edge && seg == CBTAF_SEG1 && err_clk > sjw_clk) begin
      // lengthen span one by jump width
      seg1_target <= 5'(span1_len + sjw_len);
    end else if (fall_edge && seg == CBTAF_SEG2 && err_clk < -sjw_clk) begin
      // shorten span two by jump width
      seg2_target <= 5'(span2_len - sjw_len);
    end else if (tq_tick) begin
      case (seg)
        CBTAF_SYNC: begin
          seg <= CBTAF_SEG1;
          seg_cnt <= 5'h00;
          seg1_target <= span1_len;
          seg2_target <= span2_len;
        end
        CBTAF_SEG1: begin
          if (seg_cnt == 5'(seg1_target - 5'h01)) begin
            seg <= CBTAF_SEG2;
            seg_cnt <= 5'h00;
          end else begin
            seg_cnt <= 5'(seg_cnt + 5'h01);
          end
        end
        CBTAF_SEG2: begin
          if (seg_cnt >= 5'(seg2_target - 5'h01)) begin
            seg <= CBTAF_SYNC;
            seg_cnt <= 5'h00;
          end else begin
            seg_cnt <= 5'(seg_cnt + 5'h01);
          end
        end
        default: seg <= CBTAF_SYNC;
      endcase
    end
  end
  // idle detection: eleven recessive samples
  always_ff @(posedge aclk) begin
    if (!aresetn || !can_enable) begin
      idle_cnt <= 5'h00;
      bus_idle <= 1'b0;
      sampled_bit <= 1'b1;
    end else if (hard_sync) begin
      idle_cnt <= 5'h00;
      bus_idle <= 1'b0;
    end else if (sample_strobe) begin
      sampled_bit <= rx_sync;
      if (!rx_sync) begin
        idle_cnt <= 5'h00;
      end else if (idle_cnt == 5'(IDLE_BITS - 5'h01)) begin
        bus_idle <= 1'b1;
      end else begin
        idle_cnt <= 5'(idle_cnt + 5'h01);
      end
    end
  end
  // transmit launch: recessive without a transmit engine here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      can_tx <= 1'b1;
    end else if (tx_point) begin
      can_tx <= 1'b1;
    end
  end
  // ==========================================================================
  // acceptance filter: scan one buffer per clock
  cbtaf_flt_e flt;
  logic [3:0] scan_idx;
  logic [3:0] hit_idx;
  logic [4:0] copy_cnt;
  logic [31:0] buf_id;
  logic [31:0] use_mask;
  logic [3:0] buf_st;
  logic id_match;
  logic took;
  assign buf_id = {buf_mem[scan_idx*WORDS_PER_BUF+W_IDH], buf_mem[scan_idx*WORDS_PER_BUF+W_IDL]};
  assign buf_st = buf_mem[scan_idx*WORDS_PER_BUF+W_CTL][3:0];
  // buffer 14 has its own mask
  assign use_mask = (scan_idx == 4'(CATCHALL_BUF)) ? catchall_id_mask : shared_id_mask;
  // set mask bits are don't care
  assign id_match = ((buf_id ^ hidden_id) & ~use_mask) == 32'h0000_0000;
  assign took = id_match && !locked[scan_idx] && !hidden_remote &&
                (buf_st == ST_RX_READY || buf_st == ST_RX_FULL);
  // remote answer: scheduled in one pass
  logic [NUM_BUF-1:0] remote_hit;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flt <= CBTAF_IDLE;
      scan_idx <= 4'h0;
      hit_idx <= 4'h0;
      copy_cnt <= 5'h00;
    end else begin
      case (flt)
        CBTAF_IDLE: begin
          if (frame_valid) begin
            flt <= CBTAF_SCAN;
            scan_idx <= 4'h0;
          end
        end
        CBTAF_SCAN: begin
          if (took) begin
            flt <= CBTAF_COPY;
            hit_idx <= scan_idx;
            copy_cnt <= 5'h00;
          end else if (scan_idx == 4'(NUM_BUF - 1)) begin
            flt <= CBTAF_IDLE;
          end else begin
            scan_idx <= 4'(scan_idx + 4'h1);
          end
        end
        CBTAF_COPY: begin
          if (copy_cnt == 5'(COPY_CYCLES - 5'h01)) begin
            flt <= CBTAF_IDLE;
          end else begin
            copy_cnt <= 5'(copy_cnt + 5'h01);
          end
        end
        default: flt <= CBTAF_IDLE;
      endcase
    end
  end
  logic copy_done;
  assign copy_done = (flt == CBTAF_COPY) && (copy_cnt == 5'(COPY_CYCLES - 5'h01));
  // ==========================================================================
  // axi4-lite write channel: takes address and data in either order
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic wr_buf;
  logic [6:0] wr_word;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign wr_buf = aw_addr >= BUF_BASE_OFFS && aw_addr < 12'(BUF_BASE_OFFS + NUM_BUF*WORDS_PER_BUF*4);
  assign wr_word = 7'((aw_addr - BUF_BASE_OFFS) >> 2);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_buf || aw_addr <= HIDDEN_CTL_OFFS) && aw_addr[1:0] == 2'b00 ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // register writes
  logic wr_reg;
  assign wr_reg = wr_go && &w_strb;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timing_config_register <= TIMING_RESET;
      shared_id_mask <= MASK_RESET;
      catchall_id_mask <= MASK_RESET;
      can_enable <= 1'b0;
      hold_after_receive <= 1'b0;
      hidden_id <= 32'h0000_0000;
      hidden_len <= 4'h0;
      hidden_remote <= 1'b0;
      frame_valid <= 1'b0;
    end else begin
      // validation pulse from a bus write of the valid bit, only when filter idle
      frame_valid <= wr_reg && aw_addr == HIDDEN_CTL_OFFS && w_data[8] && flt == CBTAF_IDLE;
      if (wr_reg && flt == CBTAF_IDLE) begin
        case (aw_addr)
          TIMING_CONFIG_OFFS: timing_config_register <= w_data;
          SHARED_MASK_OFFS: shared_id_mask <= w_data;
          CATCHALL_MASK_OFFS: catchall_id_mask <= w_data;
          CONFIG_OFFS: begin
            can_enable <= w_data[0];
            hold_after_receive <= w_data[1];
          end
          HIDDEN_ID_OFFS: hidden_id <= w_data;
          HIDDEN_CTL_OFFS: begin
            hidden_len <= w_data[3:0];
            hidden_remote <= w_data[4];
          end
          default: hidden_len <= hidden_len;
        endcase
      end
    end
  end
  // ==========================================================================
  // buffer ram: bus writes, filter copy and remote scheduling
  logic [NUM_BUF-1:0] remote_match;
  always_comb begin
    for (int i = 0; i < NUM_BUF; i++) begin
      remote_match[i] = hidden_remote && buf_mem[i*WORDS_PER_BUF+W_CTL][3:0] == ST_TX_RTR &&
        ((({buf_mem[i*WORDS_PER_BUF+W_IDH], buf_mem[i*WORDS_PER_BUF+W_IDL]} ^ hidden_id) &
        ~((i == CATCHALL_BUF) ? catchall_id_mask : shared_id_mask)) == 32'h0000_0000);
    end
  end
  assign remote_hit = frame_valid ? remote_match : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_BUF*WORDS_PER_BUF; i++) begin
        buf_mem[i] <= 16'h0000;
      end
      locked <= '0;
    end else begin
      // 15 buffers of 8 words, each rx or tx
      if (wr_go && wr_buf) begin
        if (w_strb[0]) buf_mem[wr_word][7:0] <= w_data[7:0];
        if (w_strb[1]) buf_mem[wr_word][15:8] <= w_data[15:8];
        if (wr_word[2:0] == 3'(W_CTL) && w_strb[0] && w_data[3:0] == ST_RX_READY) begin
          locked[wr_word[6:3]] <= 1'b0;
        end
      end
      // remote frame schedules every answering buffer
      for (int i = 0; i < NUM_BUF; i++) begin
        if (remote_hit[i]) buf_mem[i*WORDS_PER_BUF+W_CTL][3:0] <= ST_TX_ONCE_RTR;
      end
      if (copy_done) begin
        buf_mem[hit_idx*WORDS_PER_BUF+W_IDH] <= hidden_id[31:16];
        buf_mem[hit_idx*WORDS_PER_BUF+W_IDL] <= hidden_id[15:0];
        buf_mem[hit_idx*WORDS_PER_BUF+W_CTL][15:12] <= hidden_len;
        buf_mem[hit_idx*WORDS_PER_BUF+W_CTL][3:0] <=
          (buf_mem[hit_idx*WORDS_PER_BUF+W_CTL][3:0] == ST_RX_READY) ? ST_RX_FULL : ST_RX_OVERRUN;
        if (hold_after_receive) locked[hit_idx] <= 1'b1;
      end
    end
  end
  always_comb begin
    tx_request = 1'b0;
    for (int i = 0; i < NUM_BUF; i++) begin
      if (buf_mem[i*WORDS_PER_BUF+W_CTL][3:0] == ST_TX_ONCE || buf_mem[i*WORDS_PER_BUF+W_CTL][3:0] == ST_TX_ONCE_RTR)
        tx_request = 1'b1;
    end
  end
  // ==========================================================================
  // axi4-lite read channel
  logic [6:0] rd_word;
  assign rd_word = 7'((s_axi_araddr - BUF_BASE_OFFS) >> 2);
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= AXI_OKAY;
      if (s_axi_araddr >= BUF_BASE_OFFS && s_axi_araddr < 12'(BUF_BASE_OFFS + NUM_BUF*WORDS_PER_BUF*4)) begin
        s_axi_rdata <= {16'h0000, buf_mem[rd_word]};
      end else begin
        case (s_axi_araddr)
          TIMING_CONFIG_OFFS: s_axi_rdata <= timing_config_register;
          SHARED_MASK_OFFS: s_axi_rdata <= shared_id_mask;
          CATCHALL_MASK_OFFS: s_axi_rdata <= catchall_id_mask;
          CONFIG_OFFS: s_axi_rdata <= {30'h0, hold_after_receive, can_enable};
          // live state: segment, idle, filter, locks
          STATUS_OFFS: s_axi_rdata <= {locked, 6'h00, timing_legal, sampled_bit, bus_idle, flt, seg, 4'h0};
          HIDDEN_ID_OFFS: s_axi_rdata <= hidden_id;
          HIDDEN_CTL_OFFS: s_axi_rdata <= {27'h0, hidden_remote, hidden_len};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= AXI_SLVERR;
          end
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : cbtaf_top

// >>> cbtaf_node.sv
// model of a remote node on the shared can bus
`timescale 1ns/1ps
module cbtaf_node (
  input wire logic aclk, // clock
  input wire logic sof, // start one dominant span
  output logic can_rx // bus level, 1 recessive
);
  logic [5:0] cnt = 6'h00; // dominant clocks left
  // a released bus is pulled back to recessive
  always @(posedge aclk) cnt <= sof ? 6'h30 : cnt - 6'(cnt != 6'h00);
  assign can_rx = cnt == 6'h00;
endmodule : cbtaf_node

// >>> cbtaf_top_chk.sv
// port checker for the can timing and filter block
`timescale 1ns/1ps
module cbtaf_top_chk (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire logic sample_strobe, // sample point pulse
  input wire logic tx_point, // launch point pulse
  input wire logic tx_request, // send request level
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic s_axi_bvalid, // write answer valid
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic s_axi_rvalid, // read answer valid
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic [31:0] s_axi_wdata // write data
);
  // ==========================================================================
  // one clock domain, reset disables every check
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_tx; s_wr ##0 (s_axi_awaddr[11:10] == 2'h1 && s_axi_awaddr[4:0] == 5'h00 && s_axi_wdata[3:0] == 4'hc); endsequence
  property p_apart; sample_strobe |-> !tx_point; endproperty
  a_apart: assert property (p_apart) else $error("sample and launch together");
  property p_seg1; tx_point |=> !sample_strobe [*3]; endproperty
  a_seg1: assert property (p_seg1) else $error("sample too soon after launch");
  property p_tq; sample_strobe |=> !sample_strobe [*3]; endproperty
  a_tq: assert property (p_tq) else $error("samples too close");
  property p_bit; tx_point |=> !tx_point [*3]; endproperty
  a_bit: assert property (p_bit) else $error("bit too short");
  property p_txreq; s_tx |-> ##[1:2] tx_request; endproperty
  a_txreq: assert property (p_txreq) else $error("send request missing");
  // both channels held one edge after the handshake, answer registered one edge later
  property p_b; s_wr |-> ##2 s_axi_bvalid; endproperty
  a_b: assert property (p_b) else $error("write answer late");
  property p_r; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r: assert property (p_r) else $error("read answer late");
  property p_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar: assert property (p_ar) else $error("read taken while busy");
endmodule : cbtaf_top_chk
bind cbtaf_top cbtaf_top_chk u_cbtaf_top_chk (.*);

// >>> cbtaf_tb.sv
// self-checking bench for the can timing and filter block
`timescale 1ns/1ps
module testbench;
  import cbtaf_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, sof = 1'h0, can_rx, can_tx, sample_strobe, tx_point, tx_request;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int err_count = 0, comparisons = 0, n;
  always #50 aclk = ~aclk;
  cbtaf_node u_cbtaf_node (.*);
  cbtaf_top u_cbtaf_top (.*);
  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic bus(input bit w, input logic [11:0] a, input logic [31:0] d);
    logic [3:0] h;
    @(posedge aclk);
    if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    // readies are read mid-cycle, where they already hold the value of the next edge
    for (int i = 0; i < 50; i++) begin
      @(negedge aclk);
      h = {s_axi_awready, s_axi_wready, s_axi_arready, w ? s_axi_bvalid : s_axi_rvalid};
      {v, resp} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
      @(posedge aclk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} & ~h[3:1];
      {s_axi_bready, s_axi_rready} <= h[0] ? 2'h0 : {s_axi_bready, s_axi_rready};
      if (h[0]) return;
    end
    err_count++;
    conclude();
  endtask : bus
  task automatic frame(input logic [31:0] id, input logic [3:0] len);
    bus(1'h1, HIDDEN_ID_OFFS, id);
    bus(1'h1, HIDDEN_CTL_OFFS, {23'h0, 1'h1, 4'h0, len});
    n = 0;
    do bus(1'h0, STATUS_OFFS, 32'h0); while (v[7:6] != 2'h0 && ++n < 40);
    chk("filter state", 32'h0, v[7:6]);
  endtask : frame
  // counts clocks up to the next pulse; e below zero only waits
  task automatic span(input bit tx, input int e, input string s);
    n = 0;
    do @(negedge aclk); while (!(tx ? tx_point : sample_strobe) && ++n < 400);
    if (e > 0) chk(s, e, n + 1);
    if (n >= 400) begin
      err_count++;
      conclude();
    end
  endtask : span
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    bus(1'h1, TIMING_CONFIG_OFFS, 32'h1200);
    bus(1'h1, CONFIG_OFFS, 32'h3);
    span(1'h1, -1, "");
    span(1'h0, 8, "sync and span one");
    span(1'h1, 4, "span two");
    chk("transmit level", 32'h1, can_tx);
    bus(1'h1, SHARED_MASK_OFFS, 32'hff);
    chk("write response", AXI_OKAY, resp);
    bus(1'h1, 12'h002, 32'h0);
    chk("misaligned write", AXI_SLVERR, resp);
    for (int b = 0; b < 2; b++) begin
      bus(1'h1, 12'h404 + 12'(32 * b), 32'h1234);
      bus(1'h1, 12'h408 + 12'(32 * b), 32'h5600);
      bus(1'h1, 12'h400 + 12'(32 * b), 32'(ST_RX_READY));
    end
    frame(32'h1234_56a1, 4'h5);
    frame(32'h1234_56a2, 4'h6);
    frame(32'h1234_56a3, 4'h7);
    bus(1'h0, 12'h400, 32'h0);
    chk("buffer 0 control", 32'h5004, v);
    bus(1'h0, 12'h408, 32'h0);
    chk("buffer 0 id", 32'h56a1, v);
    bus(1'h0, 12'h420, 32'h0);
    chk("buffer 1 control", 32'h6004, v);
    bus(1'h0, 12'h428, 32'h0);
    chk("buffer 1 id", 32'h56a2, v);
    bus(1'h1, CATCHALL_MASK_OFFS, 32'hffff_ffff);
    bus(1'h1, 12'h5c0, 32'(ST_RX_READY));
    frame(32'h0f0f_0001, 4'h8);
    bus(1'h0, 12'h5c0, 32'h0);
    chk("buffer 14 control", 32'h8004, v);
    bus(1'h1, 12'h440, 32'(ST_TX_ONCE));
    chk("send request", 32'h1, tx_request);
    bus(1'h0, 12'h020, 32'h0);
    chk("unmapped response", AXI_SLVERR, resp);
    // align to a launch point so the free-running sample cannot land in the window
    span(1'h1, -1, "");
    @(posedge aclk);
    sof <= 1'h1;
    @(posedge aclk);
    sof <= 1'h0;
    span(1'h0, -1, "");
    chk("frame start sample", 32'h1, n >= 8 && n <= 12);
    conclude();
  end
endmodule : testbench
